// *** tb/owdc_host_model.sv ***
// Host side model: open-drain driver of the enable and one-wire line
`timescale 1ns/1ps
`default_nettype none
module owdc_host_model (
    input wire logic ref_clk_i,
    output logic host_low_o
);
    // Held low through reset so that the first rise belongs to the bench
    initial host_low_o = 1'b1;

    task automatic hold(input bit lvl, input int n);
        @(posedge ref_clk_i);
        host_low_o <= !lvl;
        repeat (n - 1) @(posedge ref_clk_i);
    endtask

    // Rise, wait past the delay, then a long low inside the window
    task automatic select_one_wire();
        hold(1'b1, 1100);
        hold(1'b0, 2700);
        hold(1'b1, 10);
    endtask

    // Bits go out LSB first; a 2:1 phase ratio tells a one from a zero
    task automatic send(input logic [23:0] w, input int n, input int u,
            input bit eos);
        for (int i = 0; i < n; i++) begin
            hold(1'b0, w[i] ? u : 2 * u);
            hold(1'b1, w[i] ? 2 * u : u);
        end
        if (eos) begin
            hold(1'b0, 2 * u);
            hold(1'b1, 80); // Released while the device acknowledges
        end
    endtask
endmodule
`default_nettype wire

// *** tb/owdc_tb_top.sv ***
// Self-checking bench of the one-wire dimming control
`timescale 1ns/1ps
`default_nettype none
module owdc_tb_top;
    localparam int WIN = 4000;
    localparam int ACK = 50;
    localparam int ENOFF = 3000;
    localparam int PWMOFF = 600;
    localparam logic [7:0] ADDR = 8'h3c; // Arbitrary value
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pwm_i = 1'b0;
    logic host_low;
    logic line_o;
    logic line_oe_o;
    logic boost_on_o;
    wire logic line_w;
    owdc_pkg::owdc_fault_t fault_i = '0;
    owdc_pkg::owdc_status_t status_o;
    logic [8:0] code_o;
    logic [8:0] scale_o;
    logic [8:0] code_last = 9'h1ff;
    logic [8:0] code_q[$];
    logic [15:0] ack_q[$];
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int ack_len = 0;
    logic [31:0] rnd = 32'h0000_0019;

    // Open drain with pull-up: low if either party pulls
    assign line_w = !(host_low || (line_oe_o && !line_o));

    owdc_top #(.DEV_ADDR(ADDR), .T_WIN_CYC(WIN), .T_ACK_CYC(ACK),
        .T_EN_OFF_CYC(ENOFF), .T_PWM_OFF_CYC(PWMOFF),
        .DUTY_WIN_LOG2(9)) i_dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .line_i(line_w),
        .line_o(line_o), .line_oe_o(line_oe_o), .pwm_i(pwm_i),
        .fault_i(fault_i), .code_o(code_o), .scale_o(scale_o),
        .boost_on_o(boost_on_o), .status_o(status_o));

    owdc_host_model i_host (.ref_clk_i(ref_clk_i), .host_low_o(host_low));

    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic tally(input bit bad, input logic [15:0] got,
            input logic [15:0] exp);
        checks++;
        if (bad) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_code(input logic [8:0] got, input logic [8:0] exp);
        tally(got !== exp, {7'h00, got}, {7'h00, exp});
    endtask

    task automatic chk_flag(input logic [2:0] got, input logic [2:0] exp);
        tally(got !== exp, {13'h0000, got}, {13'h0000, exp});
    endtask

    task automatic chk_len(input logic [15:0] got, input logic [15:0] exp);
        tally(got !== exp, got, exp);
    endtask

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watcher: every code change or acknowledge takes the oldest note
    always @(posedge ref_clk_i) begin
        if (!rst_i) begin
            if (code_o !== code_last) begin
                if (code_q.size() == 0) begin
                    chk_code(code_o, code_last);
                end else begin
                    chk_code(code_o, code_q.pop_front());
                end
            end
            code_last <= code_o;
            if (line_oe_o === 1'b1) begin
                ack_len <= ack_len + 1;
            end else if (ack_len != 0) begin
                chk_len(ack_len[15:0],
                    ack_q.size() ? ack_q.pop_front() : 16'h0000);
                ack_len <= 0;
            end
        end
    end

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        logic [23:0] w;
        logic [8:0] c;
        logic [2:0] h;
        bit ack;
        int u;
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        tick(2);
        chk_code(code_o, 9'h1ff);
        chk_code(scale_o, 9'h000);
        chk_flag(status_o, 3'b000);
        $display("test reset done");
        i_host.hold(1'b1, 20);
        chk_flag(status_o, 3'b000);
        pwm_i <= 1'b1;
        tick(WIN + 100);
        chk_flag(status_o, 3'b100);
        chk_code(scale_o, 9'h1ff);
        rnd = xs(rnd);
        h = (rnd[2:0] == 3'h0) ? 3'h4 : rnd[2:0];
        repeat (192) begin
            pwm_i <= 1'b1;
            tick(h);
            pwm_i <= 1'b0;
            tick(8 - h);
        end
        chk_code(scale_o, {h, 6'h00});
        tick(PWMOFF + 10);
        chk_flag(status_o, 3'b000);
        chk_code(scale_o, 9'h000);
        $display("test duty done");
        pwm_i <= 1'b1;
        i_host.select_one_wire();
        chk_flag(status_o, 3'b110);
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            // Index in the low bits keeps every load a visible change
            c = {rnd[8:4], 1'b0, i[2:0]};
            // Wrong address asks for an acknowledge it must not get
            ack = rnd[9] | (i == 0) | (i == 3);
            u = rnd[10] ? 20 : 60;
            w = {(i == 3) ? ADDR ^ 8'h80 : ADDR, 5'h00, ack, 1'b0, c};
            if (i == 5) begin
                i_host.send(w, 10, u, 1'b0);
                i_host.hold(1'b1, 3700);
            end else begin
                if (i != 3) begin
                    code_q.push_back(c);
                    if (ack) begin
                        ack_q.push_back(16'(ACK));
                    end
                end
                i_host.send(w, 24, u, 1'b1);
                if (i != 3) begin
                    chk_code(scale_o, c);
                end
            end
        end
        tick(10);
        chk_len(16'(code_q.size()), 16'h0000);
        chk_len(16'(ack_q.size()), 16'h0000);
        $display("test commands done");
        code_q.push_back(9'h1ff);
        i_host.hold(1'b0, ENOFF + 100);
        chk_flag(status_o, 3'b000);
        chk_code(code_o, 9'h1ff);
        i_host.hold(1'b1, WIN + 100);
        chk_flag(status_o, 3'b100);
        $display("test shutdown done");
        for (int k = 0; k < 2; k++) begin
            fault_i.thermal <= (k == 0);
            fault_i.supply_lockout <= (k == 1);
            tick(3);
            chk_flag(status_o, 3'b000);
            fault_i <= '0;
            tick(WIN + 100);
            chk_flag(status_o, 3'b100);
        end
        fault_i.overvoltage_guard <= 1'b1;
        tick(3);
        fault_i <= '0;
        tick(20);
        chk_flag(status_o, 3'b001);
        pwm_i <= 1'b0;
        tick(3);
        pwm_i <= 1'b1;
        tick(WIN + 100);
        chk_flag(status_o, 3'b100);
        chk_flag({2'b00, boost_on_o}, 3'b001);
        fault_i.current_limit <= 1'b1;
        tick(1);
        fault_i.current_limit <= 1'b0;
        tick(5);
        chk_flag({2'b00, boost_on_o}, 3'b000);
        fault_i.cycle_start <= 1'b1;
        tick(1);
        fault_i.cycle_start <= 1'b0;
        tick(2);
        chk_flag({2'b00, boost_on_o}, 3'b001);
        $display("test protection done");
        conclude();
    end
endmodule
`default_nettype wire

// *** verilog/owdc_defs.svh ***
// Timing, field and reset constants of the one-wire dimming control
`ifndef OWDC_DEFS_SVH
`define OWDC_DEFS_SVH
`define OWDC_CLK_MHZ 10
`define OWDC_T_DLY_US 100
`define OWDC_T_DET_US 260
`define OWDC_T_WIN_US 1000
`define OWDC_T_EOS_US 360
`define OWDC_T_ACK_US 512
`define OWDC_T_EN_OFF_US 2500
`define OWDC_T_PWM_OFF_US 20000
`define OWDC_DLY_CYC (`OWDC_T_DLY_US * `OWDC_CLK_MHZ)
`define OWDC_DET_CYC (`OWDC_T_DET_US * `OWDC_CLK_MHZ)
`define OWDC_WIN_CYC (`OWDC_T_WIN_US * `OWDC_CLK_MHZ)
`define OWDC_EOS_CYC (`OWDC_T_EOS_US * `OWDC_CLK_MHZ)
`define OWDC_ACK_CYC (`OWDC_T_ACK_US * `OWDC_CLK_MHZ)
`define OWDC_EN_OFF_CYC (`OWDC_T_EN_OFF_US * `OWDC_CLK_MHZ)
`define OWDC_PWM_OFF_CYC (`OWDC_T_PWM_OFF_US * `OWDC_CLK_MHZ)
`define OWDC_CODE_W 9
`define OWDC_CODE_RST 9'h1ff
`define OWDC_WORD_W 24
`define OWDC_ADDR_LSB 16
`define OWDC_ADDR_W 8
`define OWDC_ACK_BIT 10
`define OWDC_DUTY_WIN_LOG2 12
`endif

// *** verilog/owdc_pkg.sv ***
// Types shared by the one-wire dimming control
`default_nettype none
package owdc_pkg;
    typedef enum logic [2:0] {
        OWDC_OFF = 3'b000,
        OWDC_DETECT = 3'b001,
        OWDC_ONE_WIRE = 3'b010,
        OWDC_DUTY = 3'b011,
        OWDC_LATCH = 3'b100
    } owdc_state_t;

    typedef struct packed {
        logic supply_lockout;
        logic thermal;
        logic overvoltage_guard;
        logic current_limit;
        logic cycle_start;
    } owdc_fault_t;

    typedef struct packed {
        logic running;
        logic one_wire;
        logic latched;
    } owdc_status_t;
endpackage
`default_nettype wire

// *** verilog/owdc_top.sv ***
// One-wire dimming control: interface select, decoder, timeouts, protection
`timescale 1ns/1ps
`default_nettype none
`include "owdc_defs.svh"

// Operation
// - Select pulse must finish inside detection window
// - Detection repeats on every start from shutdown
// - No select pulse means duty-cycle dimming
// - Nine-bit code register, all ones initially
// - Code returns to all ones on shutdown
// - Current is full scale times code/511
// - Line low beyond 2.5 ms shuts down
// - Dimming input low beyond 20 ms shuts down
// - Start only with line and dimming high
// - Duty mode scales by measured duty cycle
// - 24 bits LSB first, address must match
// - Data holds code and acknowledge request
// - Acknowledge by pulling low on good command
// - Rate-independent decoding, 1.7 to 160 kbit/s; here any phase over 360 us aborts the word
// - Overvoltage latches off until toggle or reset
// - Current limit holds switch off this cycle
// - Thermal flag shuts down, auto resumes
// - Supply lockout shuts down, auto restarts
// - Acknowledge low lasts at most 512 us
module owdc_top #(
    parameter logic [7:0] DEV_ADDR = 8'h5a, // Arbitrary value
    parameter int T_WIN_CYC = `OWDC_WIN_CYC,
    parameter int T_ACK_CYC = `OWDC_ACK_CYC,
    parameter int T_EN_OFF_CYC = `OWDC_EN_OFF_CYC,
    parameter int T_PWM_OFF_CYC = `OWDC_PWM_OFF_CYC,
    parameter int DUTY_WIN_LOG2 = `OWDC_DUTY_WIN_LOG2
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_o,
    input wire logic pwm_i,
    input wire owdc_pkg::owdc_fault_t fault_i,
    output logic [`OWDC_CODE_W-1:0] code_o,
    output logic [`OWDC_CODE_W-1:0] scale_o,
    output logic boost_on_o,
    output owdc_pkg::owdc_status_t status_o
);
    localparam int CW = $clog2(T_PWM_OFF_CYC + T_EN_OFF_CYC + T_WIN_CYC + 2);
    localparam int RW = $clog2(`OWDC_EOS_CYC + 2);
    localparam int AW = $clog2(T_ACK_CYC + 1);
    localparam int DW = DUTY_WIN_LOG2;
    localparam int WW = `OWDC_WORD_W;

    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
        sat_inc = (&v) ? v : v + 1'b1;
    endfunction

    function automatic logic [`OWDC_CODE_W-1:0] clamp_code(
        input logic [DW:0] v);
        logic [DW:0] s;
        s = v >> (DW - `OWDC_CODE_W);
        clamp_code = (s > (DW + 1)'(`OWDC_CODE_RST)) ?
            `OWDC_CODE_RST : s[`OWDC_CODE_W-1:0];
    endfunction

    owdc_pkg::owdc_state_t state_r, state_nxt;
    logic line_q_r, pwm_q_r, fall, rise, toggle, running, en_off, pwm_off;
    logic [CW-1:0] win_r, win_nxt, dlow_r, dlow_nxt;
    logic [CW-1:0] en_cnt_r, en_cnt_nxt, pwm_cnt_r, pwm_cnt_nxt;
    logic arm_r, arm_nxt;
    owdc_pkg::owdc_status_t status_nxt;

    assign fall = line_q_r && !line_i;
    assign rise = !line_q_r && line_i;
    assign toggle = (line_q_r != line_i) || (pwm_q_r != pwm_i);
    assign running = (state_r == owdc_pkg::OWDC_ONE_WIRE) ||
        (state_r == owdc_pkg::OWDC_DUTY);
    // Counter holds cycles already low, so >= means strictly longer
    assign en_off = !line_i && en_cnt_r >= CW'(T_EN_OFF_CYC);
    assign pwm_off = !pwm_i && pwm_cnt_r >= CW'(T_PWM_OFF_CYC);
    assign line_o = 1'b0;

    always_comb begin
        state_nxt = state_r;
        win_nxt = '0;
        dlow_nxt = '0;
        arm_nxt = 1'b0;
        en_cnt_nxt = line_i ? '0 : sat_inc(en_cnt_r);
        pwm_cnt_nxt = pwm_i ? '0 : sat_inc(pwm_cnt_r);
        case (state_r)
            owdc_pkg::OWDC_OFF: begin
                if (line_i && pwm_i && !fault_i.thermal) begin
                    state_nxt = owdc_pkg::OWDC_DETECT;
                end
            end
            owdc_pkg::OWDC_DETECT: begin
                win_nxt = sat_inc(win_r);
                arm_nxt = arm_r;
                if (fall && win_r >= CW'(`OWDC_DLY_CYC)) begin
                    arm_nxt = 1'b1;
                end else if (rise) begin
                    arm_nxt = 1'b0;
                end
                if (arm_nxt && !line_i) begin
                    dlow_nxt = sat_inc(dlow_r);
                end
                if (arm_r && !line_i && dlow_r >= CW'(`OWDC_DET_CYC)) begin
                    state_nxt = owdc_pkg::OWDC_ONE_WIRE;
                end else if (win_r >= CW'(T_WIN_CYC - 1)) begin
                    state_nxt = owdc_pkg::OWDC_DUTY;
                end
            end
            owdc_pkg::OWDC_ONE_WIRE, owdc_pkg::OWDC_DUTY: begin
                if (fault_i.overvoltage_guard) begin
                    state_nxt = owdc_pkg::OWDC_LATCH;
                end
            end
            owdc_pkg::OWDC_LATCH: begin
                if (toggle) begin
                    state_nxt = owdc_pkg::OWDC_OFF;
                end
            end
            default: state_nxt = owdc_pkg::OWDC_OFF;
        endcase
        if (state_r != owdc_pkg::OWDC_OFF &&
            state_r != owdc_pkg::OWDC_LATCH && (en_off || pwm_off)) begin
            state_nxt = owdc_pkg::OWDC_OFF;
        end
        if (state_r != owdc_pkg::OWDC_LATCH && fault_i.thermal) begin
            state_nxt = owdc_pkg::OWDC_OFF;
        end
        if (fault_i.supply_lockout) begin
            state_nxt = owdc_pkg::OWDC_OFF;
        end
        status_nxt.running = state_nxt == owdc_pkg::OWDC_ONE_WIRE ||
            state_nxt == owdc_pkg::OWDC_DUTY;
        status_nxt.one_wire = state_nxt == owdc_pkg::OWDC_ONE_WIRE;
        status_nxt.latched = state_nxt == owdc_pkg::OWDC_LATCH;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= owdc_pkg::OWDC_OFF;
            win_r <= '0;
            dlow_r <= '0;
            arm_r <= 1'b0;
            en_cnt_r <= '0;
            pwm_cnt_r <= '0;
            line_q_r <= 1'b0;
            pwm_q_r <= 1'b0;
            status_o <= '0;
        end else begin
            state_r <= state_nxt;
            win_r <= win_nxt;
            dlow_r <= dlow_nxt;
            arm_r <= arm_nxt;
            en_cnt_r <= en_cnt_nxt;
            pwm_cnt_r <= pwm_cnt_nxt;
            line_q_r <= line_i;
            pwm_q_r <= pwm_i;
            status_o <= status_nxt;
        end
    end

    // Command receiver; bits are judged by phase ratio, not absolute time
    logic [RW-1:0] ph_r, ph_nxt, low_r, low_nxt;
    logic [WW-1:0] sr_r, sr_nxt, word;
    logic [4:0] bits_r, bits_nxt;
    logic seen_r, seen_nxt, have_r, have_nxt, pend_r, pend_nxt;
    logic ack_r, ack_nxt, load, addr_ok, bit_v;
    logic [AW-1:0] ack_cnt_r, ack_cnt_nxt;
    logic [`OWDC_CODE_W-1:0] code_nxt;

    assign bit_v = ph_r > low_r;
    assign word = {bit_v, sr_r[WW-1:1]};
    assign addr_ok =
        word[`OWDC_ADDR_LSB +: `OWDC_ADDR_W] == DEV_ADDR;

    always_comb begin
        ph_nxt = (rise || fall || (&ph_r)) ? (rise || fall ? '0 : ph_r)
            : ph_r + 1'b1;
        low_nxt = low_r;
        sr_nxt = sr_r;
        bits_nxt = bits_r;
        seen_nxt = seen_r;
        have_nxt = have_r;
        pend_nxt = pend_r;
        ack_nxt = ack_r;
        ack_cnt_nxt = '0;
        load = 1'b0;
        if (ack_r) begin
            ack_cnt_nxt = ack_cnt_r + 1'b1;
            if (ack_cnt_r == AW'(T_ACK_CYC - 1)) begin
                ack_nxt = 1'b0;
                ack_cnt_nxt = '0;
            end
        end else if (state_r == owdc_pkg::OWDC_ONE_WIRE) begin
            if (rise) begin
                if (pend_r) begin
                    ack_nxt = 1'b1;
                    pend_nxt = 1'b0;
                end else if (seen_r) begin
                    low_nxt = ph_r;
                    have_nxt = 1'b1;
                end
            end else if (fall) begin
                seen_nxt = 1'b1;
                if (have_r) begin
                    have_nxt = 1'b0;
                    sr_nxt = word;
                    bits_nxt = bits_r + 5'h01;
                    if (bits_r == 5'(WW - 1)) begin
                        bits_nxt = 5'h00;
                        // Stops the closing low leaking into the next word
                        seen_nxt = 1'b0;
                        load = addr_ok;
                        pend_nxt = addr_ok && word[`OWDC_ACK_BIT];
                    end
                end
            end else if (ph_r > RW'(`OWDC_EOS_CYC)) begin
                bits_nxt = 5'h00;
                seen_nxt = 1'b0;
                have_nxt = 1'b0;
                pend_nxt = 1'b0;
            end
        end else begin
            bits_nxt = 5'h00;
            seen_nxt = 1'b0;
            have_nxt = 1'b0;
            pend_nxt = 1'b0;
        end
        if (ack_r) begin
            seen_nxt = 1'b0;
            have_nxt = 1'b0;
        end
        if (state_r == owdc_pkg::OWDC_OFF ||
            state_r == owdc_pkg::OWDC_LATCH) begin
            code_nxt = `OWDC_CODE_RST;
        end else if (load) begin
            code_nxt = word[`OWDC_CODE_W-1:0];
        end else begin
            code_nxt = code_o;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ph_r <= '0;
            low_r <= '0;
            sr_r <= '0;
            bits_r <= 5'h00;
            seen_r <= 1'b0;
            have_r <= 1'b0;
            pend_r <= 1'b0;
            ack_r <= 1'b0;
            ack_cnt_r <= '0;
            code_o <= `OWDC_CODE_RST;
        end else begin
            ph_r <= ph_nxt;
            low_r <= low_nxt;
            sr_r <= sr_nxt;
            bits_r <= bits_nxt;
            seen_r <= seen_nxt;
            have_r <= have_nxt;
            pend_r <= pend_nxt;
            ack_r <= ack_nxt;
            ack_cnt_r <= ack_cnt_nxt;
            code_o <= code_nxt;
        end
    end
    assign line_oe_o = ack_r;

    // Duty measured over a fixed window; slow rates alias, a known limit
    logic [DW-1:0] dwin_r, dwin_nxt;
    logic [DW:0] hi_r, hi_nxt, hi_sum;
    logic [`OWDC_CODE_W-1:0] duty_r, duty_nxt, scale_nxt;
    logic ilim_r, ilim_nxt, boost_nxt;

    assign hi_sum = hi_r + (DW + 1)'(pwm_i);

    always_comb begin
        dwin_nxt = dwin_r + 1'b1;
        hi_nxt = hi_sum;
        duty_nxt = duty_r;
        if (&dwin_r) begin
            hi_nxt = '0;
            duty_nxt = clamp_code(hi_sum);
        end
        if (state_r != owdc_pkg::OWDC_DUTY) begin
            dwin_nxt = '0;
            hi_nxt = '0;
            duty_nxt = `OWDC_CODE_RST;
        end
        case (state_r)
            owdc_pkg::OWDC_ONE_WIRE: scale_nxt = code_o;
            owdc_pkg::OWDC_DUTY: scale_nxt = duty_r;
            default: scale_nxt = '0;
        endcase
        // Trip wins over a cycle start landing on the same edge
        ilim_nxt = fault_i.current_limit ||
            (ilim_r && !fault_i.cycle_start);
        boost_nxt = running && !ilim_nxt && !fault_i.overvoltage_guard;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            dwin_r <= '0;
            hi_r <= '0;
            duty_r <= `OWDC_CODE_RST;
            scale_o <= '0;
            ilim_r <= 1'b0;
            boost_on_o <= 1'b0;
        end else begin
            dwin_r <= dwin_nxt;
            hi_r <= hi_nxt;
            duty_r <= duty_nxt;
            scale_o <= scale_nxt;
            ilim_r <= ilim_nxt;
            boost_on_o <= boost_nxt;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    code_reset_a: assert property (
        state_r == owdc_pkg::OWDC_OFF |=> code_o == `OWDC_CODE_RST)
        else $error("code not back to all ones in shutdown");
    latch_hold_a: assert property (
        state_r == owdc_pkg::OWDC_LATCH && !toggle &&
        !fault_i.supply_lockout |=> state_r == owdc_pkg::OWDC_LATCH)
        else $error("latched off state left without toggle");
    ilim_gate_a: assert property (
        fault_i.current_limit ##1 !fault_i.cycle_start |-> !boost_on_o[*2])
        else $error("boost switch on during current limit hold");
    thermal_off_a: assert property (
        fault_i.thermal && !fault_i.overvoltage_guard |=>
        state_r == owdc_pkg::OWDC_OFF || state_r == owdc_pkg::OWDC_LATCH)
        else $error("running while thermal flag set");
    lockout_off_a: assert property (
        fault_i.supply_lockout |=> state_r == owdc_pkg::OWDC_OFF ##1
        !boost_on_o)
        else $error("running under supply lockout");
    en_timeout_a: assert property (
        running && en_off |=> state_r == owdc_pkg::OWDC_OFF)
        else $error("line low timeout did not shut down");
    pwm_timeout_a: assert property (
        running && pwm_off |=> state_r == owdc_pkg::OWDC_OFF)
        else $error("dimming low timeout did not shut down");
    start_gate_a: assert property (
        state_r == owdc_pkg::OWDC_OFF && !(line_i && pwm_i) |=>
        state_r == owdc_pkg::OWDC_OFF)
        else $error("started without both inputs high");
    fallback_a: assert property (
        state_r == owdc_pkg::OWDC_DETECT && win_r >= CW'(T_WIN_CYC - 1) &&
        !(arm_r && !line_i) && !fault_i.supply_lockout &&
        !fault_i.thermal && !en_off && !pwm_off |=>
        state_r == owdc_pkg::OWDC_DUTY)
        else $error("no fallback to duty mode after window");
    detect_only_a: assert property (
        $rose(state_r == owdc_pkg::OWDC_ONE_WIRE) |->
        $past(state_r) == owdc_pkg::OWDC_DETECT)
        else $error("one-wire mode entered without detection");
    ack_len_a: assert property (
        $rose(line_oe_o) |-> line_oe_o[*8] ##0
        (ack_cnt_r < AW'(T_ACK_CYC)))
        else $error("acknowledge pulse length wrong");
    code_load_a: assert property (
        code_o != $past(code_o) && state_r != owdc_pkg::OWDC_LATCH &&
        $past(state_r) == owdc_pkg::OWDC_ONE_WIRE |-> $past(load))
        else $error("code changed without full matching command");

    ow_cov_c: cover property (state_r == owdc_pkg::OWDC_ONE_WIRE);
    duty_cov_c: cover property (state_r == owdc_pkg::OWDC_DUTY);
    ack_cov_c: cover property ($rose(line_oe_o));
    latch_cov_c: cover property (state_r == owdc_pkg::OWDC_LATCH);
endmodule
`default_nettype wire
